// *** verilog/cpg_ctrl.sv ***
// module: clock generator control with wishbone registers
`timescale 1ns/1ps
// Function
// - mode pins sampled only at reset or standby-change
// - mode 1: external input, times four
// - mode 2: crystal source, times four
// - mode 5: external input, times two
// - mode 6: crystal source, times two
// - first stage passes or doubles
// - core clock rising edge aligned with bus pin
// - core clock equals first stage output
// - bus clock equals bus pin rate
// - peripheral clock divides first stage by 1/2/4
// - phy clock divides first stage independently
// - frequency register word access only
// - frequency register reset only by external reset
// - top three bits read zero
// - control holds or runs bus pin in standby
// - core clock gated in sleep; clocks gated in standby, module stop
// - bit 12 low-hold; entry forces two peripheral cycles
// - bits 10:8 select first stage multiplier
// - bits 2:0 peripheral divide, reset 011
// - phy register writes need key 5a
module cpg_ctrl
  import cpg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wdt_reset_i,
  input  wire logic              ext_clk_en_i,
  input  wire logic              clock_mode_pin_0_i,
  input  wire logic              clock_mode_pin_1_i,
  input  wire logic              clock_mode_pin_2_i,
  input  wire logic              wake_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  output logic                   osc_enable_o,
  output logic                   src_is_crystal_o,
  output logic      [2:0]        pll2_mult_o,
  output logic                   core_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   bus_clock_pin_o,
  output logic                   phy_clock_out_o,
  output logic      [MSTP_W-1:0] module_clk_en_o
);
  logic [15:0]       frq_q, frq_d;
  logic [7:0]        phy_q, phy_d;
  logic [15:0]       stb_q, stb_d;
  logic [2:0]        mode_q, mode_d;
  logic              bad_q, bad_d;
  logic              err_q, err_d;
  logic [31:0]       rd_q, rd_d;
  logic              ack_q, ack_d;
  cpg_pwr_t          pwr_q, pwr_d;
  logic [CNT_W-1:0]  hold_q, hold_d;
  logic              ph_q, ph_d;
  logic              bus_q, bus_d;
  logic              core_q, core_d;
  logic              wr, acc, word_ok;
  logic              boot_q, boot_d;
  logic [2:0]        pins;
  cpg_div_if         pdiv ();
  cpg_div_if         mdiv ();

  assign pins = {clock_mode_pin_2_i, clock_mode_pin_1_i, clock_mode_pin_0_i};
  assign acc  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr   = acc && wb_we_i;
  assign word_ok = (wb_sel_i == 4'h3);

  // ************************************************
  // dividers for peripheral and phy clocks
  // ************************************************
  assign pdiv.ratio = cpg_div_code(frq_q[2:0]);
  assign pdiv.run   = (pwr_q != ST_STBY);
  assign mdiv.ratio = cpg_div_code(phy_q[2:0]);
  assign mdiv.run   = (pwr_q != ST_STBY);

  cpg_divider u_pdiv (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .src_en_i (ext_clk_en_i),
    .d        (pdiv.div)
  );
  cpg_divider u_mdiv (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .src_en_i (ext_clk_en_i),
    .d        (mdiv.div)
  );

  // ************************************************
  // register bus and mode latch
  // ************************************************
  always_comb begin
    frq_d  = frq_q;
    phy_d  = phy_q;
    stb_d  = stb_q;
    mode_d = mode_q;
    bad_d  = bad_q;
    err_d  = 1'b0;
    ack_d  = 1'b0;
    rd_d   = rd_q;
    if (wdt_reset_i) begin
      phy_d = PHY_RESET;
      stb_d = 16'h0000;
    end
    if (!boot_q) begin
      mode_d = pins;
      bad_d  = !(pins inside {MODE_1, MODE_2, MODE_5, MODE_6});
    end
    if (pwr_q == ST_RUN && pwr_d == ST_ENTRY && stb_q[STB_MODE_CHANGE_ENABLE]) begin
      mode_d = pins;
      bad_d  = !(pins inside {MODE_1, MODE_2, MODE_5, MODE_6});
    end
    if (acc) begin
      ack_d = 1'b1;
      rd_d  = 32'h0000_0000;
      case (wb_adr_i)
        FRQ_OFF: begin
          if (!word_ok) begin
            ack_d = 1'b0;
            err_d = 1'b1;
          end else if (wr) begin
            frq_d = wb_dat_i[15:0] & FRQ_WMASK;
          end else begin
            rd_d = {16'h0000, frq_q & FRQ_WMASK};
          end
        end
        PHY_OFF: begin
          if (wr && word_ok && wb_dat_i[15:8] == PHY_KEY) begin
            phy_d = wb_dat_i[7:0] & PHY_WMASK;
          end
          rd_d = {24'h000000, phy_q};
        end
        STB_OFF: begin
          if (wr) begin
            stb_d = wb_dat_i[15:0];
          end
          rd_d = {16'h0000, stb_q};
        end
        STAT_OFF: rd_d = {24'h000000, bad_q, 1'b0, pwr_q, 1'b0, mode_q};
        default: begin
          ack_d = 1'b0;
          err_d = 1'b1;
        end
      endcase
    end
    if (pwr_q == ST_STBY && wake_i) begin
      stb_d[STB_STBY] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frq_q  <= FRQ_RESET;
      phy_q  <= PHY_RESET;
      stb_q  <= 16'h0000;
      mode_q <= 3'h0;
      bad_q  <= 1'b0;
      err_q  <= 1'b0;
      ack_q  <= 1'b0;
      rd_q   <= 32'h0000_0000;
    end else begin
      frq_q  <= frq_d;
      phy_q  <= phy_d;
      stb_q  <= stb_d;
      mode_q <= mode_d;
      bad_q  <= bad_d;
      err_q  <= err_d;
      ack_q  <= ack_d;
      rd_q   <= rd_d;
    end
  end

  // power-on strap capture right after release
  always_comb begin
    boot_d = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
    end
  end

  // ************************************************
  // power state: run, standby entry, standby
  // ************************************************
  always_comb begin
    pwr_d  = pwr_q;
    hold_d = hold_q;
    case (pwr_q)
      ST_RUN: begin
        if (stb_q[STB_STBY]) begin
          pwr_d  = ST_ENTRY;
          hold_d = '0;
        end
      end
      ST_ENTRY: begin
        if (pdiv.tick) begin
          hold_d = hold_q + CNT_W'(1);
        end
        if (hold_q == CNT_W'(LOWHOLD_PCYC)) begin
          pwr_d = ST_STBY;
        end
      end
      ST_STBY: begin
        if (wake_i) begin
          pwr_d = ST_RUN;
        end
      end
      default: pwr_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q  <= ST_RUN;
      hold_q <= '0;
    end else begin
      pwr_q  <= pwr_d;
      hold_q <= hold_d;
    end
  end

  // ************************************************
  // derived clocks, pll control outputs
  // ************************************************
  always_comb begin
    ph_d   = ext_clk_en_i ? ~ph_q : ph_q;
    core_d = ph_d;
    bus_d  = ph_d;
    if (frq_q[FRQ_MUL_HI:FRQ_MUL_LO] == MUL_X2) begin
      bus_d = (core_d && !core_q) ? ~bus_q : bus_q;
    end
    if (pwr_q == ST_ENTRY) begin
      bus_d = 1'b0;
    end else if (pwr_q == ST_STBY) begin
      bus_d = frq_q[FRQ_OE_BIT] ? ext_clk_en_i : 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q   <= 1'b0;
      core_q <= 1'b0;
      bus_q  <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      core_q <= core_d;
      bus_q  <= bus_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_o     <= 1'b0;
      src_is_crystal_o <= 1'b0;
      pll2_mult_o      <= 3'h4;
      core_clk_en_o    <= 1'b0;
      periph_clk_en_o  <= 1'b0;
      bus_clock_pin_o  <= 1'b0;
      phy_clock_out_o  <= 1'b0;
      module_clk_en_o  <= '0;
    end else begin
      osc_enable_o     <= (boot_q ? (mode_q[1] && !mode_q[0]) : (pins[1] && !pins[0]))
                          && pwr_q != ST_STBY;
      src_is_crystal_o <= boot_q ? (mode_q[1] && !mode_q[0]) : (pins[1] && !pins[0]);
      pll2_mult_o      <= (boot_q ? mode_q[2] : pins[2]) ? 3'h2 : 3'h4;
      core_clk_en_o    <= core_d && pwr_q == ST_RUN && !stb_q[STB_SLEEP];
      periph_clk_en_o  <= pdiv.level && pwr_q == ST_RUN;
      bus_clock_pin_o  <= bus_d;
      phy_clock_out_o  <= mdiv.level;
      module_clk_en_o  <= (pwr_q == ST_RUN) ? ~stb_q[STB_MSTP_LO +: MSTP_W] : '0;
    end
  end

  always_comb begin
    wb_dat_o = rd_q;
    wb_ack_o = ack_q;
    wb_err_o = err_q;
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_entry;
    pwr_q == ST_RUN ##1 pwr_q == ST_ENTRY;
  endsequence
  a_entry_low: assert property (@(posedge clk_i) disable iff (rst_i)
    s_entry |=> !bus_clock_pin_o) else $error("bus pin not low at entry");
  a_stby_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_q == ST_STBY && !frq_q[FRQ_OE_BIT] |=> !bus_clock_pin_o)
    else $error("bus pin toggles in standby");
  a_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    frq_q[15:13] == 3'h0) else $error("reserved bits set");
  a_key_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == PHY_OFF && wb_dat_i[15:8] != PHY_KEY |=> $stable(phy_q))
    else $error("phy register written without key");
  a_word_only: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == FRQ_OFF && !word_ok |=> $stable(frq_q) && wb_err_o)
    else $error("frequency register took a non-word write");
  a_mode_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_q != ST_RUN |=> $stable(mode_q)) else $error("mode changed outside sampling");
  a_core_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_q == ST_STBY |=> !core_clk_en_o && !periph_clk_en_o)
    else $error("clock running in standby");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    acc |=> wb_ack_o || wb_err_o) else $error("bus access not answered");
endmodule : cpg_ctrl

// *** verilog/cpg_pkg.sv ***
// package: register map, field layout and constants of the clock generator control
package cpg_pkg;
  // ************************************************
  // register offsets (byte addresses)
  // ************************************************
  localparam logic [3:0]  FRQ_OFF      = 4'h0;
  localparam logic [3:0]  PHY_OFF      = 4'h4;
  localparam logic [3:0]  STB_OFF      = 4'h8;
  localparam logic [3:0]  STAT_OFF     = 4'hc;
  // ************************************************
  // frequency control fields
  // ************************************************
  localparam int          FRQ_OE_BIT   = 12;
  localparam int          FRQ_MUL_LO   = 8;
  localparam int          FRQ_MUL_HI   = 10;
  localparam logic [15:0] FRQ_RESET    = 16'h1003;
  localparam logic [15:0] FRQ_WMASK    = 16'h1707;
  localparam logic [2:0]  MUL_X1       = 3'h0;
  localparam logic [2:0]  MUL_X2       = 3'h1;
  localparam logic [2:0]  DIV_1        = 3'h0;
  localparam logic [2:0]  DIV_2        = 3'h1;
  localparam logic [2:0]  DIV_4        = 3'h3;
  // ************************************************
  // phy clock control
  // ************************************************
  localparam logic [7:0]  PHY_KEY      = 8'h5a;
  localparam logic [7:0]  PHY_RESET    = 8'h43;
  localparam logic [7:0]  PHY_WMASK    = 8'hc7;
  // ************************************************
  // standby control fields
  // ************************************************
  localparam int          STB_SLEEP    = 0;
  localparam int          STB_STBY     = 1;
  localparam int          STB_MODE_CHANGE_ENABLE    = 2;
  localparam int          STB_MSTP_LO  = 8;
  localparam int          MSTP_W       = 8;
  // ************************************************
  // modes and timing
  // ************************************************
  localparam logic [2:0]  MODE_1       = 3'h1;
  localparam logic [2:0]  MODE_2       = 3'h2;
  localparam logic [2:0]  MODE_5       = 3'h5;
  localparam logic [2:0]  MODE_6       = 3'h6;
  localparam int          LOWHOLD_PCYC = 2;
  localparam int          CNT_W        = 4;

  typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_STBY} cpg_pwr_t;

  // ratio code to half-period count minus one (tick divider of 1,2,4)
  function automatic logic [1:0] cpg_div_code(input logic [2:0] code);
    case (code)
      DIV_2:   cpg_div_code = 2'h1;
      DIV_4:   cpg_div_code = 2'h3;
      default: cpg_div_code = 2'h0;
    endcase
  endfunction : cpg_div_code
endpackage : cpg_pkg

// *** verilog/cpg_div_if.sv ***
// interface: divider control and clock-enable output between modules
`timescale 1ns/1ps
interface cpg_div_if;
  logic [1:0] ratio;
  logic       run;
  logic       tick;
  logic       level;
  modport ctrl (output ratio, output run, input tick, input level);
  modport div  (input ratio, input run, output tick, output level);
endinterface : cpg_div_if

// *** verilog/cpg_divider.sv ***
// module: glitch-free clock divider producing a level and a tick per output period
`timescale 1ns/1ps
module cpg_divider
  import cpg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic src_en_i,
  cpg_div_if.div    d
);
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] ratio_q, ratio_d;
  logic       lvl_q, lvl_d;
  logic       tick_q, tick_d;

  // ************************************************
  // ratio applied at a period boundary or while stopped
  // ************************************************
  always_comb begin
    cnt_d   = cnt_q;
    ratio_d = ratio_q;
    lvl_d   = lvl_q;
    tick_d  = 1'b0;
    if (!d.run) begin
      cnt_d   = 2'h0;
      lvl_d   = 1'b0;
      ratio_d = d.ratio;
    end else if (src_en_i) begin
      if (cnt_q == ratio_q) begin
        cnt_d = 2'h0;
        lvl_d = ~lvl_q;
        if (lvl_q) begin
          tick_d  = 1'b1;
          ratio_d = d.ratio;
        end
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= 2'h0;
      ratio_q <= 2'h0;
      lvl_q   <= 1'b0;
      tick_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ratio_q <= ratio_d;
      lvl_q   <= lvl_d;
      tick_q  <= tick_d;
    end
  end

  assign d.tick  = tick_q;
  assign d.level = lvl_q;

  a_ratio_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= ratio_q) else $error("divider count above ratio");
  a_hold_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    !d.run |=> !lvl_q) else $error("divider level not low when stopped");
endmodule : cpg_divider

// *** verif/cpg_src_model.sv ***
// partner model: edge pulses of the external clock or crystal source
`timescale 1ns/1ps
module cpg_src_model #(
  parameter int PERIOD = 16
) (
  input  wire logic clk_i,
  output logic      tick_o
);
  // free running, as a crystal keeps oscillating through reset
  int cnt_q = 0;
  always_ff @(posedge clk_i) begin
    cnt_q  <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    tick_o <= (cnt_q == PERIOD - 1);
  end
endmodule : cpg_src_model

// *** verif/cpg_ctrl_tb_top.sv ***
// testbench: wishbone driven checks of the clock generator control
`timescale 1ns/1ps
module cpg_ctrl_tb_top
  import cpg_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wdt_r = 1'b0;
  logic        wake  = 1'b0;
  logic        tick;
  logic [2:0]  md    = 3'h1;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [3:0]  sel   = 4'h0;
  logic        we    = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        osc_en;
  logic        crys;
  logic [2:0]  mult;
  logic        core;
  logic        per;
  logic        bus;
  logic        phy;
  logic [7:0]  men;
  logic [31:0] q;
  logic        e;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          c0, c1, c2, c3, mis;
  logic [15:0] fv [5] = '{16'h1000, 16'h1001, 16'h1003, 16'h1101, 16'h1103};
  logic [2:0]  pd [3] = '{DIV_1, DIV_2, DIV_4};
  logic [2:0]  mp [4] = '{MODE_1, MODE_2, MODE_5, MODE_6};
  always #2 clk_i = ~clk_i;
  cpg_src_model #(.PERIOD(16)) cpg_src_model_i (.clk_i(clk_i), .tick_o(tick));
  cpg_ctrl cpg_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wdt_reset_i(wdt_r), .ext_clk_en_i(tick),
    .clock_mode_pin_0_i(md[0]), .clock_mode_pin_1_i(md[1]), .clock_mode_pin_2_i(md[2]),
    .wake_i(wake), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .osc_enable_o(osc_en), .src_is_crystal_o(crys), .pll2_mult_o(mult),
    .core_clk_en_o(core), .periph_clk_en_o(per), .bus_clock_pin_o(bus),
    .phy_clock_out_o(phy), .module_clk_en_o(men));
  // ************************************************
  // tasks
  // ************************************************
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("FAIL %s expected %h seen %h", nm, x, g);
      n_errors++;
    end
  endtask : chk
  task automatic near(input string nm, input int x, input int g);
    n_compared++;
    if (g > x + 3 || g < x - 3 || g == 0) begin
      $display("FAIL %s expected %0d seen %0d", nm, x, g);
      n_errors++;
    end
  endtask : near
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    adr <= a;
    we  <= w;
    dat <= d;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk("bus_answer", 2, n);
  endtask : xfer
  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0, 4'h3);
    chk(nm, x, q);
  endtask : rd
  task automatic state(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      xfer(STAT_OFF, 1'b0, 32'h0, 4'h3);
      n++;
    end while (q[5:4] !== s && n < 64);
    chk("pwr_state", s, q[5:4]);
  endtask : state
  task automatic do_wake;
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    state(2'h0);
  endtask : do_wake
  task automatic count(input int k);
    logic [3:0] pv;
    logic [3:0] r;
    {c0, c1, c2, c3, mis} = '0;
    pv = 4'hf;
    repeat (k) begin
      @(posedge clk_i);
      r = {phy, bus, per, core} & ~pv;
      pv = {phy, bus, per, core};
      c0 += r[0];
      c1 += r[1];
      c2 += r[2];
      c3 += r[3];
      mis += (r[2] && !r[0]);
    end
  endtask : count
  function automatic int dv(input logic [2:0] c);
    return (c == DIV_1) ? 1 : (c == DIV_2) ? 2 : 4;
  endfunction : dv
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    md <= 3'h6;
    rd("freq_reset", FRQ_OFF, 32'h1003);
    rd("phy_reset", PHY_OFF, 32'h43);
    rd("status_mode", STAT_OFF, 32'h1);
    chk("pll2_mode1", 3'h4, mult);
    chk("src_mode1", 1'b0, crys);
    chk("mod_en", 8'hff, men);
    xfer(FRQ_OFF, 1'b1, 32'hf101, 4'h3);
    rd("freq_mask", FRQ_OFF, 32'h1101);
    xfer(FRQ_OFF, 1'b1, 32'h1000, 4'h1);
    chk("freq_byte_err", 1'b1, e);
    rd("freq_byte_kept", FRQ_OFF, 32'h1101);
    xfer(4'h2, 1'b0, 32'h0, 4'h3);
    chk("unmapped_err", 1'b1, e);
    xfer(PHY_OFF, 1'b1, 32'h0041, 4'h3);
    rd("phy_nokey", PHY_OFF, 32'h43);
    xfer(PHY_OFF, 1'b1, 32'h5a41, 4'h1);
    rd("phy_bytesel", PHY_OFF, 32'h43);
    for (int i = 0; i < 5; i++) begin
      xfer(FRQ_OFF, 1'b1, {16'h0, fv[i]}, 4'h3);
      xfer(PHY_OFF, 1'b1, {16'h0, 8'h5a, 2'h1, 3'h0, pd[i % 3]}, 4'h3);
      rd("freq_rb", FRQ_OFF, {16'h0, fv[i]});
      rd("phy_rb", PHY_OFF, {24'h0, 2'h1, 3'h0, pd[i % 3]});
      repeat (256) @(posedge clk_i);
      count(1600);
      near("core_vs_bus", c2 * (fv[i][8] ? 2 : 1), c0);
      near("per_vs_core", c0, c1 * dv(fv[i][2:0]));
      near("phy_vs_core", c0, c3 * dv(pd[i % 3]));
      chk("edge_align", 0, mis);
    end
    xfer(FRQ_OFF, 1'b1, 32'h1101, 4'h3);
    wdt_r <= 1'b1;
    repeat (2) @(posedge clk_i);
    wdt_r <= 1'b0;
    rd("freq_wdt_kept", FRQ_OFF, 32'h1101);
    rd("phy_wdt_reset", PHY_OFF, 32'h43);
    rd("mode_ignored", STAT_OFF, 32'h1);
    for (int i = 0; i < 4; i++) begin
      md <= mp[i];
      xfer(STB_OFF, 1'b1, 32'h6, 4'h3);
      state(2'h2);
      chk("mode_latched", {1'b0, mp[i]}, {q[7], q[2:0]});
      chk("pll2_mult", (i < 2) ? 3'h4 : 3'h2, mult);
      chk("src_crystal", i[0], crys);
      chk("osc_stby_off", 1'b0, osc_en);
      count(200);
      if (!i[0]) chk("bus_stby_runs", 1'b1, c2 > 0);
      do_wake();
      chk("osc_enable", i[0], osc_en);
    end
    md <= 3'h1;
    xfer(STB_OFF, 1'b1, 32'h2, 4'h3);
    state(2'h2);
    chk("mode_kept", 3'h6, q[2:0]);
    do_wake();
    md <= 3'h3;
    xfer(STB_OFF, 1'b1, 32'h6, 4'h3);
    state(2'h2);
    chk("mode_unsup", 1'b1, q[7]);
    do_wake();
    md <= 3'h1;
    xfer(STB_OFF, 1'b1, 32'h6, 4'h3);
    state(2'h2);
    do_wake();
    xfer(FRQ_OFF, 1'b1, 32'h0003, 4'h3);
    xfer(STB_OFF, 1'b1, 32'h2, 4'h3);
    state(2'h2);
    count(200);
    chk("bus_stby_low", 0, c2);
    do_wake();
    xfer(STB_OFF, 1'b1, 32'h0501, 4'h3);
    count(200);
    chk("core_sleep", 0, c0);
    chk("mod_stop", 8'hfa, men);
    xfer(STB_OFF, 1'b1, 32'h0, 4'h3);
    chk("mod_run", 8'hff, men);
    end_of_test();
  end
endmodule : cpg_ctrl_tb_top
